/* hdl/host_bus_pkg.sv */
// Shared constants and types for the host bus control block.
package host_bus_pkg;

	// ************************************************************
	// Register map on the APB side
	// ************************************************************
	localparam logic [7:0] OFS_BUS_WIDTH = 8'h00;
	localparam logic [7:0] OFS_VRETRACE  = 8'h04;
	localparam logic [7:0] OFS_STATUS    = 8'h08;

	// Field positions.
	localparam int BW_ROM_WIDE_BIT = 1;
	localparam int BW_MEM_WIDE_BIT = 2;
	localparam int VR_CLR_N_BIT    = 4;
	localparam int VR_IRQ_EN_BIT   = 5;
	localparam int ST_IRQ_BIT      = 0;
	localparam int ST_SETUP_BIT    = 1;
	localparam int ST_AWAKE_BIT    = 2;
	localparam int ST_WAIT_BIT     = 3;
	localparam int ST_CHAN_BIT     = 4;

	// Values after reset.
	localparam logic [7:0] BUS_WIDTH_RST = 8'h00;
	localparam logic [7:0] VRETRACE_RST  = 8'h00;

	// ************************************************************
	// Host address decode windows
	// ************************************************************
	localparam logic [15:0] IO_SETUP_ADDR = 16'h0102;
	localparam logic [15:0] IO_EXT_ADDR   = 16'h03C3;
	localparam logic [15:0] IO_REG_LO     = 16'h03B0;
	localparam logic [15:0] IO_REG_HI     = 16'h03DF;
	localparam logic [19:0] VID_LO        = 20'hA0000;
	localparam logic [19:0] VID_HI        = 20'hBFFFF;
	localparam logic [19:0] ROM_LO        = 20'hC0000;
	localparam logic [19:0] ROM_HI        = 20'hC7FFF;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		KIND_VIDEO,
		KIND_ROM,
		KIND_IO
	} hit_kind_t;

	// Raw multiplexed control pins, all from the host bus.
	typedef struct packed {
		logic mem_read_n;
		logic mem_write_n;
		logic io_read_n;
		logic io_write_n;
		logic io_enable_setup_n;
		logic high_byte_enable_n;
		logic display_mem_enable;
	} host_pins_t;

	// One decoded host access handed to the internal decode.
	typedef struct packed {
		hit_kind_t   kind;
		logic        write;
		logic [1:0]  lanes;
		logic [19:0] addr;
		logic [7:0]  wdata;
	} host_req_t;

endpackage

/* hdl/host_bus_control.sv */
// Host bus control: strobe decode, wait states, feedback and interrupt.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

// Contract
// - Bus-style mode: ROM width feedback is the inverse of ROM width bit.
// - Channel mode: ROM width feedback low on any adapter-addressed access.
// - Ready drops during video accesses until the access completes.
// - Ready never drops for I/O or ROM cycles.
// - Interrupt request only while the enable bit 5 is set.
// - Interrupt active high in bus-style mode, active low in channel mode.
// - End of vertical display latches interrupt until bit 4 clears it.
// - Bus-style mode: data-size output follows bus-width bit 2.
// - Bus-style mode: I/O answered only while I/O enable is low.
// - Channel mode: enable high operates normally, low means setup mode.
// - Setup mode ignores all own I/O registers except ports 102H and 3C3H.
// - Writing 1 to port 102H in setup mode wakes the device.
// - Port 3C3H and ROM stay reachable in setup mode.
// - High byte enable with A0 selects the byte lanes.
// - High byte enable ignored for I/O; I/O uses the low lane.
// - Channel mode: memory-read pin is the memory or I/O qualifier.
// - Memory-write pin: write strobe, or channel status bit 0.
// - I/O-read pin: read strobe, or channel status bit 1.
// - I/O-write pin: write strobe, or channel command strobe.
// - Bus-style video accesses need display memory enable; ROM does not.
module host_bus_control
	import host_bus_pkg::*;
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Static configuration.
	input  wire logic        channel_mode,
	// Host bus pins.
	input  wire host_pins_t  sys_pins,
	input  wire logic [19:0] sys_addr,
	input  wire logic [7:0]  sys_data_lo,
	output logic             ready,
	output logic             irq,
	output logic             rom_width_feedback_n,
	output logic             wide_transfer_n,
	// Internal memory, I/O and ROM side.
	input  wire logic        vdisp_end,
	input  wire logic        mem_done,
	output logic             req_valid,
	output host_req_t        req
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	host_pins_t  pins_s1_q;
	host_pins_t  pins_q;
	logic [19:0] addr_s1_q;
	logic [19:0] addr_q;
	logic [7:0]  data_s1_q;
	logic [7:0]  data_q;

	// Two stages per pin; the first stage feeds only the second.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_s1_q <= 7'h7E;
			pins_q    <= 7'h7E;
			addr_s1_q <= 20'h00000;
			addr_q    <= 20'h00000;
			data_s1_q <= 8'h00;
			data_q    <= 8'h00;
		end else begin
			pins_s1_q <= sys_pins;
			pins_q    <= pins_s1_q;
			addr_s1_q <= sys_addr;
			addr_q    <= addr_s1_q;
			data_s1_q <= sys_data_lo;
			data_q    <= data_s1_q;
		end
	end

	// ************************************************************
	// Registers and state
	// ************************************************************
	typedef enum {
		ST_IDLE,
		ST_WAIT,
		ST_HOLD
	} cyc_state_t;

	cyc_state_t state_q;
	cyc_state_t state_d;
	logic [7:0] bus_width_ctrl_reg_q;
	logic [7:0] vretrace_end_reg_q;
	logic       irq_latch_q;
	logic       awake_q;
	logic       active_prev_q;

	// ************************************************************
	// Cycle decode
	// ************************************************************
	logic is_mem;
	logic is_io;
	logic is_write;
	logic active;
	logic [15:0] io_addr;
	logic vid_hit;
	logic rom_hit;
	logic setup_hit;
	logic ext_hit;
	logic reg_hit;
	logic setup_mode;
	logic io_hit;
	logic adapter_hit;
	logic start;

	// The mode input picks how the four strobe pins are read.
	always_comb begin
		if (channel_mode) begin
			// Command strobe qualifies the cycle.
			active   = !pins_q.io_write_n;
			// Qualifier high is memory, low is I/O.
			is_mem   = active && pins_q.mem_read_n;
			is_io    = active && !pins_q.mem_read_n;
			// Status 0 low marks a write, status 1 a read.
			is_write = !pins_q.mem_write_n && pins_q.io_read_n;
		end else begin
			// Separate strobes, all active low.
			is_mem   = !pins_q.mem_read_n || !pins_q.mem_write_n;
			is_io    = !pins_q.io_read_n || !pins_q.io_write_n;
			is_write = !pins_q.mem_write_n || !pins_q.io_write_n;
			active   = is_mem || is_io;
		end
	end

	assign io_addr = addr_q[15:0];

	// Video window; bus-style mode also needs the enable pin.
	assign vid_hit = is_mem && addr_q >= VID_LO && addr_q <= VID_HI
		&& (channel_mode || pins_q.display_mem_enable);

	// ROM accesses never look at the display enable.
	assign rom_hit = is_mem && addr_q >= ROM_LO
		&& addr_q <= ROM_HI;

	assign setup_hit = is_io && io_addr == IO_SETUP_ADDR;
	assign ext_hit   = is_io && io_addr == IO_EXT_ADDR;
	assign reg_hit   = is_io && io_addr >= IO_REG_LO
		&& io_addr <= IO_REG_HI;

	// Setup mode follows the enable pin in channel mode only.
	assign setup_mode = channel_mode
		&& !pins_q.io_enable_setup_n;

	// Which I/O ports answer depends on mode and setup state.
	always_comb begin
		if (!channel_mode) begin
			// Enable pin gates all own I/O.
			io_hit = !pins_q.io_enable_setup_n
				&& (reg_hit || ext_hit);
		end else if (setup_mode) begin
			// Only the setup port and the external port.
			io_hit = setup_hit || ext_hit;
		end else if (awake_q) begin
			io_hit = reg_hit || ext_hit;
		end else begin
			// Asleep until woken; the external port still works.
			io_hit = ext_hit;
		end
	end

	// ROM stays reachable whatever the setup state.
	assign adapter_hit = vid_hit || rom_hit || io_hit;
	assign start = active && !active_prev_q && adapter_hit;

	// Remember the previous strobe level for edge detection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_prev_q <= 1'b0;
		end else begin
			active_prev_q <= active;
		end
	end

	// ************************************************************
	// Request to the internal decode
	// ************************************************************
	// One request per host cycle, captured at its first edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_valid <= 1'b0;
			req       <= '0;
		end else begin
			req_valid <= start;
			if (start) begin
				req.kind  <= is_io ? KIND_IO
					: (rom_hit ? KIND_ROM : KIND_VIDEO);
				req.write <= is_write;
				req.addr  <= addr_q;
				req.wdata <= data_q;
				if (is_io) begin
					// I/O moves on the low lane only.
					req.lanes <= 2'h1;
				end else begin
					// Byte lanes from high enable and A0.
					req.lanes <= {!pins_q.high_byte_enable_n,
						!addr_q[0]};
				end
			end
		end
	end

	// ************************************************************
	// Wait-state sequencer
	// ************************************************************
	// Only video accesses wait for the memory controller.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start && vid_hit) begin
					state_d = ST_WAIT;
				end else if (start) begin
					state_d = ST_HOLD;
				end
			end
			ST_WAIT: begin
				if (mem_done) begin
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (!active) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Ready falls in the very cycle a video access starts, so no
	// extra cycle of latency is added on top of the synchroniser.
	assign ready = !(state_q == ST_WAIT
		|| (state_q == ST_IDLE && start && vid_hit));

	// ************************************************************
	// Wake-up from setup mode
	// ************************************************************
	// A write of 1 to the setup port wakes the device; 0 puts it
	// back to sleep. Only honoured while in setup mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			awake_q <= 1'b0;
		end else if (start && setup_mode && setup_hit && is_write) begin
			awake_q <= data_q[0];
		end
	end

	// ************************************************************
	// Feedback outputs
	// ************************************************************
	// Both outputs are registered so the pins never glitch.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rom_width_feedback_n <= 1'b1;
			wide_transfer_n      <= 1'b0;
		end else if (channel_mode) begin
			rom_width_feedback_n <= !adapter_hit;
			wide_transfer_n <= !((rom_hit
				&& bus_width_ctrl_reg_q[BW_ROM_WIDE_BIT])
				|| (vid_hit
				&& bus_width_ctrl_reg_q[BW_MEM_WIDE_BIT]));
		end else begin
			rom_width_feedback_n <=
				!bus_width_ctrl_reg_q[BW_ROM_WIDE_BIT];
			wide_transfer_n <=
				bus_width_ctrl_reg_q[BW_MEM_WIDE_BIT];
		end
	end

	// ************************************************************
	// APB slave
	// ************************************************************
	logic apb_setup;
	logic apb_wr;
	logic mapped;
	logic clr_write;

	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite && mapped;
	assign mapped    = paddr == OFS_BUS_WIDTH
		|| paddr == OFS_VRETRACE
		|| (paddr == OFS_STATUS && !pwrite);

	// Zero wait states; unmapped or read-only writes are errors.
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Writable registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_width_ctrl_reg_q <= BUS_WIDTH_RST;
			vretrace_end_reg_q   <= VRETRACE_RST;
		end else if (apb_wr) begin
			if (paddr == OFS_BUS_WIDTH) begin
				bus_width_ctrl_reg_q <= pwdata[7:0];
			end
			if (paddr == OFS_VRETRACE) begin
				vretrace_end_reg_q <= pwdata[7:0];
			end
		end
	end

	// Read data is prepared in the setup phase, ready for access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (apb_setup) begin
			case (paddr)
				OFS_BUS_WIDTH: prdata <= {24'h000000,
					bus_width_ctrl_reg_q};
				OFS_VRETRACE:  prdata <= {24'h000000,
					vretrace_end_reg_q};
				OFS_STATUS: begin
					prdata <= 32'h00000000;
					prdata[ST_IRQ_BIT]   <= irq_latch_q;
					prdata[ST_SETUP_BIT] <= setup_mode;
					prdata[ST_AWAKE_BIT] <= awake_q;
					prdata[ST_WAIT_BIT]  <= state_q == ST_WAIT;
					prdata[ST_CHAN_BIT]  <= channel_mode;
				end
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// ************************************************************
	// Vertical interrupt
	// ************************************************************
	assign clr_write = apb_wr && paddr == OFS_VRETRACE
		&& !pwdata[VR_CLR_N_BIT];

	// A frame end in the same cycle as a clear still sets the latch.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_latch_q <= 1'b0;
		end else if (vdisp_end
			&& vretrace_end_reg_q[VR_IRQ_EN_BIT]) begin
			irq_latch_q <= 1'b1;
		end else if (clr_write) begin
			irq_latch_q <= 1'b0;
		end
	end

	// Pin polarity flips with the bus mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= channel_mode ^ (irq_latch_q
				&& vretrace_end_reg_q[VR_IRQ_EN_BIT]);
		end
	end

endmodule

/* tb/host_bus_chk.sv */
// Port-level checker for the host bus control block.
`timescale 1ns/1ps
module host_bus_chk
	import host_bus_pkg::*;
(
	// Clock and reset.
	input wire logic		pclk,
	input wire logic		presetn,
	// Register bus.
	input wire logic [7:0]	paddr,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [31:0]	pwdata,
	// Mode and host side outputs.
	input wire logic		channel_mode,
	input wire logic		ready,
	input wire logic		irq,
	input wire logic		rom_width_feedback_n,
	input wire logic		wide_transfer_n,
	// Internal side.
	input wire logic		vdisp_end,
	input wire logic		mem_done,
	input wire logic		req_valid,
	input wire host_req_t	req
);
	logic [2:1]	bw_q;
	logic		vr5_q, live_q, wr_bw, wr_vr, clr_w, act;

	// Register writes on the bus; pready never stalls, so access is enough.
	assign wr_bw = psel && penable && pwrite && paddr == OFS_BUS_WIDTH;
	assign wr_vr = psel && penable && pwrite && paddr == OFS_VRETRACE;
	assign clr_w = wr_vr && !pwdata[VR_CLR_N_BIT];
	assign act = irq ^ channel_mode;

	// Shadows of the width bits and the interrupt enable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bw_q <= '0;
			vr5_q <= 1'b0;
			live_q <= 1'b0;
		end else begin
			live_q <= 1'b1;
			if (wr_bw) bw_q <= pwdata[2:1];
			if (wr_vr) vr5_q <= pwdata[VR_IRQ_EN_BIT];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// A clear write with no new frame end around it.
	sequence clr_s;
		clr_w && !vdisp_end ##1 !vdisp_end;
	endsequence
	sequence vid_req_s;
		req_valid && req.kind == KIND_VIDEO;
	endsequence

	rom_fb_a: assert property (!channel_mode && $stable(bw_q) |->
		rom_width_feedback_n == !bw_q[1])
		else $error("rom width feedback wrong");
	wide_isa_a: assert property (!channel_mode && $stable(bw_q) |->
		wide_transfer_n == bw_q[2])
		else $error("data size output wrong");
	wait_vid_a: assert property ($fell(ready) |=> vid_req_s)
		else $error("wait state outside video access");
	wait_end_a: assert property (mem_done && !ready |=> ready)
		else $error("ready not restored");
	io_lane_a: assert property (req_valid && req.kind == KIND_IO |->
		req.lanes == 2'b01 && ready)
		else $error("io lanes or ready wrong");
	irq_gate_a: assert property (live_q && act |-> $past(vr5_q))
		else $error("interrupt while disabled");
	irq_set_a: assert property (vdisp_end && vr5_q |=> ##1 act)
		else $error("interrupt not raised");
	irq_clr_a: assert property (clr_s |=> irq == channel_mode)
		else $error("interrupt not cleared");
endmodule

bind host_bus_control host_bus_chk u_chk (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.channel_mode(channel_mode), .ready(ready), .irq(irq),
	.rom_width_feedback_n(rom_width_feedback_n),
	.wide_transfer_n(wide_transfer_n), .vdisp_end(vdisp_end),
	.mem_done(mem_done), .req_valid(req_valid), .req(req)
);

/* tb/host_bus_model.sv */
// Host bus master model driving the multiplexed control pins.
`timescale 1ns/1ps
module host_bus_model
	import host_bus_pkg::*;
(
	// Clock.
	input wire logic	pclk,
	// Host bus pins.
	output host_pins_t	sys_pins,
	output logic [19:0]	sys_addr,
	output logic [7:0]	sys_data_lo
);
	// Idle bus: every strobe high, display memory disabled.
	initial begin
		sys_pins = 7'h7E;
		sys_addr = '0;
		sys_data_lo = '0;
	end

	// One host cycle; the address leads the strobe by one clock.
	task automatic xfer(logic cm, logic io, logic w, logic [19:0] a,
		logic [7:0] d, logic bn, logic en, logic dm);
		host_pins_t p;
		p = sys_pins;
		p.io_enable_setup_n = en;
		p.high_byte_enable_n = bn;
		p.display_mem_enable = dm;
		if (cm) begin
			p.mem_read_n = !io;
			p.mem_write_n = !w;
			p.io_read_n = w;
		end
		sys_pins <= p;
		sys_addr <= a;
		sys_data_lo <= d;
		@(posedge pclk);
		if (cm || (io && w)) p.io_write_n = 1'b0;
		else if (io) p.io_read_n = 1'b0;
		else if (w) p.mem_write_n = 1'b0;
		else p.mem_read_n = 1'b0;
		sys_pins <= p;
		repeat (14) @(posedge pclk);
		// Released address, data and high byte enable show inverses; strobes go high.
		p[6:3] = 4'hF;
		p[1] = !bn;
		sys_pins <= p;
		sys_addr <= ~a;
		sys_data_lo <= ~d;
		repeat (4) @(posedge pclk);
	endtask
endmodule

/* tb/host_bus_control_tb.sv */
// Self-checking bench for the host bus control block.
`timescale 1ns/1ps
module host_bus_control_tb;
	import host_bus_pkg::*;
	logic		pclk, presetn, psel, penable, pwrite, cm, vde, mdone;
	logic		pready, pslverr, ready, irq, fb_n, wide_n, rv, err;
	logic [7:0]	paddr, sd;
	logic [31:0]	pwdata, prdata, rdat;
	logic [19:0]	sa;
	host_pins_t	pins;
	host_req_t	req;
	int		n_mismatch, n_checks, bw, awake;

	host_bus_control dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.channel_mode(cm), .sys_pins(pins), .sys_addr(sa),
		.sys_data_lo(sd), .ready(ready), .irq(irq),
		.rom_width_feedback_n(fb_n), .wide_transfer_n(wide_n),
		.vdisp_end(vde), .mem_done(mdone), .req_valid(rv), .req(req)
	);
	host_bus_model hm (.pclk(pclk), .sys_pins(pins), .sys_addr(sa),
		.sys_data_lo(sd));

	// Free-running 10 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic check(string nm, logic [31:0] s, logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic tally_and_finish;
		if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// One APB transfer; waits for pready under a bound.
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge keeps a following call from re-driving psel now.
		@(posedge pclk);
		if (i == 20) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask

	// Host cycle against a decode model of the expected answer.
	task automatic hx(logic io, logic w, logic [19:0] a, logic [7:0] d,
		logic bn, logic en, logic dm);
		logic		acc, rh, eh;
		hit_kind_t	k;
		int		i;
		rh = a[15:0] >= IO_REG_LO && a[15:0] <= IO_REG_HI;
		eh = a[15:0] == IO_EXT_ADDR;
		k = io ? KIND_IO : (a >= ROM_LO ? KIND_ROM : KIND_VIDEO);
		acc = (a >= ROM_LO && a <= ROM_HI) || (a >= VID_LO &&
			a <= VID_HI && (cm || dm));
		if (io && !cm) acc = !en && (rh || eh);
		else if (io && !en) acc = eh || a[15:0] == IO_SETUP_ADDR;
		else if (io) acc = eh || (awake != 0 && rh);
		fork
			hm.xfer(cm, io, w, a, d, bn, en, dm);
			begin
				for (i = 0; i < 12; i++) begin
					@(negedge pclk);
					if (rv === 1'b1) break;
				end
				check("req_valid", i < 12, acc);
				if (acc) begin
					check("kind", req.kind, k);
					check("write", req.write, w);
					check("lanes", req.lanes, io ? 2'b01 : {!bn, !a[0]});
					check("addr", req.addr, a);
					if (w) check("wdata", req.wdata, d);
					check("ready", ready, k != KIND_VIDEO);
					repeat (2) @(negedge pclk);
					check("fb", fb_n, cm ? 0 : !bw[1]);
					check("wide", wide_n, cm ? !((k == KIND_ROM && bw[1]) ||
						(k == KIND_VIDEO && bw[2])) : bw[2]);
					// At least one edge, so mem_done moves on a rising edge.
					repeat (1 + $urandom_range(3)) @(posedge pclk);
					mdone <= (k == KIND_VIDEO);
					@(posedge pclk);
					mdone <= 1'b0;
					@(negedge pclk);
					check("ready_end", ready, 1);
				end
			end
		join
		if (cm) check("fb_idle", fb_n, 1);
		if (cm && acc && io && w && !en && !eh) awake = d[0];
	endtask

	// Interrupt: raise, clear, then masked frame end.
	task automatic irq_seq;
		apb(1'b1, OFS_VRETRACE, 32'h30);
		vde <= 1'b1;
		@(posedge pclk);
		vde <= 1'b0;
		repeat (3) @(negedge pclk);
		check("irq_on", irq, !cm);
		apb(1'b1, OFS_VRETRACE, 32'h20);
		repeat (3) @(negedge pclk);
		check("irq_clr", irq, cm);
		apb(1'b1, OFS_VRETRACE, 32'h10);
		vde <= 1'b1;
		@(posedge pclk);
		vde <= 1'b0;
		repeat (3) @(negedge pclk);
		check("irq_mask", irq, cm);
	endtask

	// Full pass in one bus mode, entered through reset.
	task automatic run(logic mode);
		logic [31:0] st;
		// Reset and mode change start on a rising edge.
		@(posedge pclk);
		presetn <= 1'b0;
		cm <= mode;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		awake = 0;
		apb(1'b0, OFS_BUS_WIDTH, 0);
		check("bw_rst", rdat, 32'(BUS_WIDTH_RST));
		apb(1'b0, 8'h0C, 0);
		check("unmapped", err, 1);
		apb(1'b1, OFS_STATUS, 32'hFF);
		check("ro_write", err, 1);
		bw = $urandom & 6;
		apb(1'b1, OFS_BUS_WIDTH, bw);
		apb(1'b0, OFS_BUS_WIDTH, 0);
		check("bw_back", rdat, bw);
		check("no_err", err, 0);
		hx(1'b0, 1'b0, VID_LO | (20'($urandom) & 20'h1FFFF), 8'h00,
			1'($urandom), 1'b1, 1'b1);
		hx(1'b0, 1'b1, VID_LO | (20'($urandom) & 20'h1FFFF), 8'h5A,
			1'b0, 1'b1, 1'b0);
		hx(1'b0, 1'b0, ROM_LO | (20'($urandom) & 20'h07FFF), 8'h00,
			1'($urandom), 1'b1, 1'b0);
		hx(1'b1, 1'b1, 20'h003C4, 8'($urandom), 1'b0, 1'b0, 1'b1);
		hx(1'b1, 1'b0, 20'h003C4, 8'h00, 1'b0, 1'b1, 1'b1);
		hx(1'b1, 1'b1, 20'(IO_SETUP_ADDR), 8'h01, 1'b0, 1'b0, 1'b1);
		hx(1'b1, 1'b0, 20'(IO_EXT_ADDR), 8'h00, 1'b1, 1'b0, 1'b1);
		hx(1'b1, 1'b1, 20'h003C4, 8'($urandom), 1'b1, 1'b1, 1'b1);
		hx(1'b0, 1'b0, 20'h00100, 8'h00, 1'b0, 1'b1, 1'b1);
		// Status: mode and wake state only; no latch, no wait, no setup.
		st = (32'(cm) << ST_CHAN_BIT) | (32'(awake) << ST_AWAKE_BIT);
		apb(1'b0, OFS_STATUS, 32'h00000000);
		check("status", rdat, st);
		irq_seq();
	endtask

	// Main sequence: both bus modes, then the verdict.
	initial begin
		void'($urandom(56));
		{presetn, psel, penable, pwrite, cm, vde, mdone} = '0;
		paddr = '0;
		pwdata = '0;
		run(1'b0);
		run(1'b1);
		tally_and_finish();
	end
endmodule
